//--- rtl/clock_config_pkg.sv
// constants and decoders shared by the pll and boost clock configuration block
package clock_config_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] PLL_CONTROL_ADDR         = 8'h01;
   localparam logic [7:0] BOOST_CLOCK_CONTROL_ADDR = 8'h02;
   localparam logic [7:0] BIAS_BOOST_CONTROL_ADDR  = 8'h03;

   // ==========================================================
   // field positions
   localparam int PLL_LOCK_BIT      = 7;
   localparam int PLL_SPEED_LSB     = 5;
   localparam int PLL_SRC_BIT       = 4;
   localparam int PLL_ENABLE_BIT    = 3;
   localparam int PLL_RATIO_LSB     = 0;
   localparam int HPF_ENABLE_BIT    = 7;
   localparam int BOOST_RATE_LSB    = 5;
   localparam int BOOST_FREQ_BIT    = 4;
   localparam int BIAS_LEVEL_LSB    = 4;
   localparam int BIAS_ENABLE_BIT   = 3;
   localparam int BOOST_ENABLE_BIT  = 2;

   // ==========================================================
   // reset values
   localparam logic [6:0] PLL_CONTROL_RESET  = 7'h01;
   localparam logic [3:0] BOOST_CLOCK_RESET  = 4'h4;
   localparam logic [7:0] BIAS_BOOST_RESET   = 8'h00;

   // ==========================================================
   // encodings and analog scaling
   localparam logic [1:0] RATE_32K          = 2'b00;
   localparam logic [1:0] RATE_44K1         = 2'b01;
   localparam logic [1:0] RATE_48K          = 2'b10;
   localparam logic [13:0] BIAS_BASE_MV     = 14'd5000;
   localparam logic [13:0] BIAS_STEP_MV     = 14'd500;
   localparam logic [3:0] BIAS_TOP_CODE     = 4'h8;
   localparam int HPF_SHIFT                 = 12;
   localparam int LOCK_REF_EDGES_DEFAULT    = 64;

   typedef enum logic [2:0]
   {
      PLL_OFF     = 3'b001,
      PLL_ACQUIRE = 3'b010,
      PLL_LOCKED  = 3'b100
   } pll_state_type;

   // ==========================================================
   // decoders
   function automatic logic [9:0] ratio_base(input logic [2:0] code);
      case (code)
         3'b000:  ratio_base = 10'd128;
         3'b001:  ratio_base = 10'd256;
         3'b010:  ratio_base = 10'd384;
         3'b011:  ratio_base = 10'd512;
         3'b100:  ratio_base = 10'd768;
         default: ratio_base = 10'd0;
      endcase
   endfunction : ratio_base

   function automatic logic [5:0] boost_divisor(input logic [1:0] rate, input logic high);
      case (rate)
         RATE_32K:  boost_divisor = high ? 6'd12 : 6'd22;
         RATE_44K1: boost_divisor = high ? 6'd16 : 6'd30;
         default:   boost_divisor = high ? 6'd16 : 6'd32;
      endcase
   endfunction : boost_divisor
endpackage : clock_config_pkg

//--- rtl/pll_boost_clock_config.sv
// pll reference, lock status, boost switching clock, bias and dc-removal control
//
// Summary of operation
// - pll reference is master clock pin or frame clock pin, per source bit.
// - frame clock reference serves sample rates from 32 to 192 kHz.
// - ratio codes 0-4 give 128..768 fs; halved at 96k, quartered at 192k.
// - lock status is a read-only bit of pll control, polled by software.
// - boost converter is clocked from the pll output, tracking sample rate.
// - one boost control bit picks high or low switching frequency.
// - boost clock is 1024 fs over 12/16/16 (high) or 22/30/32 (low).
// - four-bit level field sets bias output from 5 V to 9 V.
// - enable bit in bias/boost register switches bias output on and off.
// - input dc offset passes to output unless high-pass filter is enabled.
// - first-order high-pass, about 1.9 Hz at 48 kHz, scaling with sample rate.
// - each level step up to code 8 adds half a volt to the bias.
// - boost stays off after reset until its enable bit is set.
`timescale 1ns/10ps
module pll_boost_clock_config
   import clock_config_pkg::*;
#(
   parameter int LOCK_REF_EDGES = clock_config_pkg::LOCK_REF_EDGES_DEFAULT,
   parameter int SAMPLE_WIDTH   = 24
)
(
   input  wire logic                    mclk_i,
   input  wire logic                    rst_n_i,
   input  wire logic [7:0]              reg_addr_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   input  wire logic [7:0]              reg_wdata_i,
   output logic      [7:0]              reg_rdata_o,
   input  wire logic                    master_clock_in_i,
   input  wire logic                    frame_clock_i,
   input  wire logic                    pll_tick_i,
   input  wire logic signed [SAMPLE_WIDTH-1:0] sample_i,
   input  wire logic                    sample_valid_i,
   output logic signed [SAMPLE_WIDTH-1:0] sample_o,
   output logic                         sample_valid_o,
   output logic                         pll_ref_frame_o,
   output logic                         pll_locked_o,
   output logic      [9:0]              pll_multiplier_o,
   output logic                         boost_enable_o,
   output logic                         boost_clk_o,
   output logic      [3:0]              bias_level_select_o,
   output logic      [13:0]             bias_mv_o,
   output logic                         bias_output_en_o
);
   import clock_config_pkg::*;

   // ==========================================================
   // elaboration checks
   if (LOCK_REF_EDGES < 1 || LOCK_REF_EDGES > 65535)
      $error("LOCK_REF_EDGES must be 1 to 65535");
   if (SAMPLE_WIDTH < 8)
      $error("SAMPLE_WIDTH must be at least 8");

   localparam logic [15:0] LOCK_TARGET = 16'(LOCK_REF_EDGES - 1);
   localparam int          ACC_W       = SAMPLE_WIDTH + HPF_SHIFT;

   // ==========================================================
   // control registers
   logic [6:0]    pll_ctrl_reg;
   logic [3:0]    boost_ctrl_reg;
   logic [7:0]    bias_ctrl_reg;
   logic          wr_pll;
   logic          setting_change;

   assign wr_pll         = reg_wr_i && (reg_addr_i == PLL_CONTROL_ADDR);
   // a write that changes source, ratio or speed forces a fresh acquisition; rewriting the same value does not
   assign setting_change = wr_pll && (reg_wdata_i[6:0] != pll_ctrl_reg);

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pll_ctrl_reg   <= PLL_CONTROL_RESET;
         boost_ctrl_reg <= BOOST_CLOCK_RESET;
         bias_ctrl_reg  <= BIAS_BOOST_RESET;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            PLL_CONTROL_ADDR:         pll_ctrl_reg   <= reg_wdata_i[6:0];
            BOOST_CLOCK_CONTROL_ADDR: boost_ctrl_reg <= reg_wdata_i[7:4];
            BIAS_BOOST_CONTROL_ADDR:  bias_ctrl_reg  <= reg_wdata_i;
            default:                  ;
         endcase
      end
   end

   // ==========================================================
   // register read port; lock bit is read-only, unused boost bits and unmapped addresses read zero
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            PLL_CONTROL_ADDR:         reg_rdata_o <= {pll_locked_o, pll_ctrl_reg};
            BOOST_CLOCK_CONTROL_ADDR: reg_rdata_o <= {boost_ctrl_reg, 4'h0};
            BIAS_BOOST_CONTROL_ADDR:  reg_rdata_o <= bias_ctrl_reg;
            default:                  reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // pll reference select and lock acquisition
   pll_state_type pll_state_reg;
   logic [15:0]   edge_cnt_reg;
   logic          ref_reg;
   logic          ref_now;
   logic          ref_edge;
   logic          pll_en;

   assign pll_en   = pll_ctrl_reg[PLL_ENABLE_BIT];
   assign ref_now  = pll_ctrl_reg[PLL_SRC_BIT] ? frame_clock_i : master_clock_in_i;
   assign ref_edge = ref_now && !ref_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ref_reg <= 1'b0;
      else
         ref_reg <= ref_now;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pll_state_reg <= PLL_OFF;
         edge_cnt_reg  <= 16'h0000;
      end
      else if (!pll_en || setting_change)
      begin
         pll_state_reg <= pll_en ? PLL_ACQUIRE : PLL_OFF;
         edge_cnt_reg  <= 16'h0000;
      end
      else
      begin
         case (pll_state_reg)
            PLL_OFF:
            begin
               pll_state_reg <= PLL_ACQUIRE;
               edge_cnt_reg  <= 16'h0000;
            end
            PLL_ACQUIRE:
               if (ref_edge)
               begin
                  if (edge_cnt_reg == LOCK_TARGET)
                     pll_state_reg <= PLL_LOCKED;
                  edge_cnt_reg <= edge_cnt_reg + 16'h0001;
               end
            PLL_LOCKED:
               pll_state_reg <= PLL_LOCKED;
            default:
               pll_state_reg <= PLL_OFF;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pll_locked_o     <= 1'b0;
         pll_ref_frame_o  <= 1'b0;
         pll_multiplier_o <= 10'd0;
      end
      else
      begin
         // lock drops at once on disable or setting change
         pll_locked_o    <= (pll_state_reg == PLL_LOCKED) && pll_en && !setting_change;
         pll_ref_frame_o <= pll_ctrl_reg[PLL_SRC_BIT];
         // frame clock mode needs no ratio: the pll locks to fs itself, 32..192 kHz
         if (pll_ctrl_reg[PLL_SRC_BIT])
            pll_multiplier_o <= 10'd0;
         else
         begin
            case (pll_ctrl_reg[PLL_SPEED_LSB +: 2])
               2'b00:   pll_multiplier_o <= ratio_base(pll_ctrl_reg[PLL_RATIO_LSB +: 3]);
               2'b01:   pll_multiplier_o <= ratio_base(pll_ctrl_reg[PLL_RATIO_LSB +: 3]) >> 1;
               default: pll_multiplier_o <= ratio_base(pll_ctrl_reg[PLL_RATIO_LSB +: 3]) >> 2;
            endcase
         end
      end
   end

   // ==========================================================
   // boost switching clock from the pll 1024 fs tick
   logic [5:0] half_div;
   logic [4:0] sw_cnt_reg;
   logic       boost_run;

   assign half_div  = boost_divisor(boost_ctrl_reg[BOOST_RATE_LSB - 4 +: 2],
                                    boost_ctrl_reg[BOOST_FREQ_BIT - 4]) >> 1;
   // no switching without a locked pll clock, so the converter never runs off-frequency
   assign boost_run = bias_ctrl_reg[BOOST_ENABLE_BIT] && pll_locked_o;

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sw_cnt_reg     <= 5'd0;
         boost_clk_o    <= 1'b0;
         boost_enable_o <= 1'b0;
      end
      else
      begin
         boost_enable_o <= bias_ctrl_reg[BOOST_ENABLE_BIT];
         if (!boost_run)
         begin
            sw_cnt_reg  <= 5'd0;
            boost_clk_o <= 1'b0;
         end
         else if (pll_tick_i)
         begin
            // >= keeps a mid-count divisor change from overrunning
            if ({1'b0, sw_cnt_reg} >= half_div - 6'd1)
            begin
               sw_cnt_reg  <= 5'd0;
               boost_clk_o <= !boost_clk_o;
            end
            else
               sw_cnt_reg <= sw_cnt_reg + 5'd1;
         end
      end
   end

   // ==========================================================
   // microphone bias level and enable
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bias_level_select_o <= 4'h0;
         bias_mv_o           <= BIAS_BASE_MV;
         bias_output_en_o    <= 1'b0;
      end
      else
      begin
         bias_level_select_o <= bias_ctrl_reg[BIAS_LEVEL_LSB +: 4];
         // codes above the top step clamp at 9 V
         if (bias_ctrl_reg[BIAS_LEVEL_LSB +: 4] >= BIAS_TOP_CODE)
            bias_mv_o <= BIAS_BASE_MV + 14'(BIAS_TOP_CODE * BIAS_STEP_MV);
         else
            bias_mv_o <= BIAS_BASE_MV + 14'(bias_ctrl_reg[BIAS_LEVEL_LSB +: 4] * BIAS_STEP_MV);
         bias_output_en_o <= bias_ctrl_reg[BIAS_ENABLE_BIT];
      end
   end

   // ==========================================================
   // first-order dc removal; pole per sample so cutoff tracks fs
   logic signed [ACC_W-1:0]        dc_acc_reg;
   logic signed [SAMPLE_WIDTH:0]   hpf_diff;
   logic signed [SAMPLE_WIDTH-1:0] dc_est;
   logic                           hpf_en;

   assign hpf_en   = boost_ctrl_reg[HPF_ENABLE_BIT - 4];
   assign dc_est   = dc_acc_reg[ACC_W-1:HPF_SHIFT];
   assign hpf_diff = (SAMPLE_WIDTH + 1)'(sample_i) - (SAMPLE_WIDTH + 1)'(dc_est);

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dc_acc_reg     <= '0;
         sample_o       <= '0;
         sample_valid_o <= 1'b0;
      end
      else
      begin
         sample_valid_o <= sample_valid_i;
         if (!hpf_en)
         begin
            dc_acc_reg <= '0;
            if (sample_valid_i)
               sample_o <= sample_i;
         end
         else if (sample_valid_i)
         begin
            dc_acc_reg <= dc_acc_reg + ACC_W'(sample_i) - ACC_W'(dc_est);
            // saturate rather than wrap on a full-scale step
            if (hpf_diff[SAMPLE_WIDTH] != hpf_diff[SAMPLE_WIDTH-1])
               sample_o <= hpf_diff[SAMPLE_WIDTH] ? {1'b1, {(SAMPLE_WIDTH-1){1'b0}}}
                                                  : {1'b0, {(SAMPLE_WIDTH-1){1'b1}}};
            else
               sample_o <= hpf_diff[SAMPLE_WIDTH-1:0];
         end
      end
   end
endmodule : pll_boost_clock_config

//--- testbench/pll_boost_clock_config_props.sv
// assertion checker for the pll and boost clock configuration block
`timescale 1ns/10ps
module pll_boost_clock_config_props
   import clock_config_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        pll_tick_i,
   input wire logic        sample_valid_i,
   input wire logic        sample_valid_o,
   input wire logic        pll_ref_frame_o,
   input wire logic        pll_locked_o,
   input wire logic [9:0]  pll_multiplier_o,
   input wire logic        boost_enable_o,
   input wire logic        boost_clk_o,
   input wire logic [3:0]  bias_level_select_o,
   input wire logic [13:0] bias_mv_o,
   input wire logic        bias_output_en_o
);
   // ==========================================================
   // sequences
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence wr_pll;
      reg_wr_i && reg_addr_i == PLL_CONTROL_ADDR;
   endsequence
   sequence wr_bias;
      reg_wr_i && reg_addr_i == BIAS_BOOST_CONTROL_ADDR;
   endsequence
   // ==========================================================
   // properties
   AST_REF_SELECT: assert property (wr_pll |-> ##2
      pll_ref_frame_o == $past(reg_wdata_i[PLL_SRC_BIT], 2)) else $error("reference select");
   AST_FRAME_MULT: assert property (pll_ref_frame_o |-> pll_multiplier_o == 10'h000)
      else $error("multiplier in frame mode");
   AST_LOCK_READ: assert property (reg_rd_i && reg_addr_i == PLL_CONTROL_ADDR |=>
      reg_rdata_o[PLL_LOCK_BIT] == $past(pll_locked_o)) else $error("lock bit read");
   AST_LOCK_DROP: assert property (wr_pll ##0 (pll_locked_o && !reg_wdata_i[PLL_ENABLE_BIT])
      |=> !pll_locked_o) else $error("lock kept after disable");
   AST_BOOST_RISE: assert property ($rose(boost_clk_o) |-> $past(pll_tick_i))
      else $error("boost clock moved without tick");
   AST_BOOST_OFF: assert property (!boost_enable_o [*2] |-> !boost_clk_o)
      else $error("boost clock while disabled");
   AST_BOOST_EN: assert property (wr_bias |-> ##2
      boost_enable_o == $past(reg_wdata_i[BOOST_ENABLE_BIT], 2)) else $error("boost enable");
   AST_BIAS_EN: assert property (wr_bias |-> ##2
      bias_output_en_o == $past(reg_wdata_i[BIAS_ENABLE_BIT], 2)) else $error("bias enable");
   AST_BIAS_MV: assert property (bias_level_select_o <= BIAS_TOP_CODE |->
      bias_mv_o == BIAS_BASE_MV + BIAS_STEP_MV * bias_level_select_o) else $error("bias level");
   AST_UNMAPPED: assert property (reg_rd_i && (reg_addr_i == 8'h00 || reg_addr_i > 8'h03)
      |=> reg_rdata_o == 8'h00) else $error("unmapped read");
   AST_SAMPLE_VALID: assert property (sample_valid_i |=> sample_valid_o)
      else $error("sample valid lost");
endmodule : pll_boost_clock_config_props

bind pll_boost_clock_config pll_boost_clock_config_props i_props (.mclk_i(mclk_i),
   .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pll_tick_i(pll_tick_i),
   .sample_valid_i(sample_valid_i), .sample_valid_o(sample_valid_o),
   .pll_ref_frame_o(pll_ref_frame_o), .pll_locked_o(pll_locked_o),
   .pll_multiplier_o(pll_multiplier_o), .boost_enable_o(boost_enable_o),
   .boost_clk_o(boost_clk_o), .bias_level_select_o(bias_level_select_o),
   .bias_mv_o(bias_mv_o), .bias_output_en_o(bias_output_en_o));

//--- testbench/clock_source_model.sv
// external clock master: master clock pin, frame clock pin and pll tick
`timescale 1ns/10ps
module clock_source_model
(
   input  wire logic mclk_i,
   input  wire logic mclk_run_i,
   input  wire logic frame_run_i,
   output logic      master_clock_in_o = 1'b0,
   output logic      frame_clock_o = 1'b0,
   output logic      pll_tick_o = 1'b0
);
   logic [1:0] count_reg = 2'h0;
   // ==========================================================
   // clocks stand low when stopped, so a stale level never looks like an edge
   always @(posedge mclk_i)
   begin
      count_reg <= count_reg + 2'h1;
      pll_tick_o <= count_reg[0];
      master_clock_in_o <= mclk_run_i & (master_clock_in_o ^ count_reg[0]);
      frame_clock_o <= frame_run_i & (frame_clock_o ^ (count_reg == 2'h3));
   end
endmodule : clock_source_model

//--- testbench/testbench.sv
// self-checking testbench for the pll and boost clock configuration block
`timescale 1ns/10ps
module testbench;
   import clock_config_pkg::*;
   logic               mclk_i = 1'b0;
   logic               rst_n_i = 1'b0;
   logic [7:0]         reg_addr_i = 8'h00;
   logic               reg_wr_i = 1'b0;
   logic               reg_rd_i = 1'b0;
   logic [7:0]         reg_wdata_i = 8'h00;
   logic signed [23:0] sample_i = 24'sh000000;
   logic               sample_valid_i = 1'b0;
   logic               mclk_run = 1'b0;
   logic               frame_run = 1'b0;
   logic               master_clock_in_i, frame_clock_i, pll_tick_i;
   logic signed [23:0] sample_o;
   logic [7:0]         reg_rdata_o, rd_val;
   logic [9:0]         pll_multiplier_o;
   logic [3:0]         bias_level_select_o;
   logic [13:0]        bias_mv_o;
   logic               sample_valid_o, pll_ref_frame_o, pll_locked_o, boost_enable_o;
   logic               boost_clk_o, bias_output_en_o;
   int                 miscompares = 0;
   int                 comparisons = 0;

   always #25 mclk_i = ~mclk_i;

   clock_source_model i_clock_source_model (.mclk_i(mclk_i), .mclk_run_i(mclk_run),
      .frame_run_i(frame_run), .master_clock_in_o(master_clock_in_i),
      .frame_clock_o(frame_clock_i), .pll_tick_o(pll_tick_i));

   pll_boost_clock_config #(.LOCK_REF_EDGES(4)) i_pll_boost_clock_config (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .master_clock_in_i(master_clock_in_i), .frame_clock_i(frame_clock_i),
      .pll_tick_i(pll_tick_i), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
      .sample_o(sample_o), .sample_valid_o(sample_valid_o), .pll_ref_frame_o(pll_ref_frame_o),
      .pll_locked_o(pll_locked_o), .pll_multiplier_o(pll_multiplier_o),
      .boost_enable_o(boost_enable_o), .boost_clk_o(boost_clk_o),
      .bias_level_select_o(bias_level_select_o), .bias_mv_o(bias_mv_o),
      .bias_output_en_o(bias_output_en_o));

   // ==========================================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic results();
      if (miscompares == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1;
      rd_val = reg_rdata_o;
   endtask : rd

   task automatic settle();
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : settle

   task automatic wait_lock();
      int n;
      n = 0;
      while (pll_locked_o !== 1'b1 && n < 400)
      begin
         @(posedge mclk_i);
         n++;
      end
      #1;
      check("lock_wait", pll_locked_o, 1);
      if (pll_locked_o !== 1'b1)
         results();
   endtask : wait_lock

   task automatic send(input logic signed [23:0] x, input logic [31:0] e);
      @(posedge mclk_i);
      sample_i <= x;
      sample_valid_i <= 1'b1;
      @(posedge mclk_i);
      sample_valid_i <= 1'b0;
      #1;
      check("sample_valid", sample_valid_o, 1);
      check("sample", sample_o, e);
   endtask : send

   // ==========================================================
   // scenarios
   task automatic t_regs();
      rd(8'h01);
      check("pll_reset", rd_val, 8'h01);
      rd(8'h02);
      check("boost_reset", rd_val, 8'h40);
      rd(8'h03);
      check("bias_reset", rd_val, 8'h00);
      rd(8'h07);
      check("unmapped", rd_val, 8'h00);
      wr(8'h02, 8'hff);
      rd(8'h02);
      check("boost_low_bits", rd_val, 8'hf0);
      wr(8'h01, 8'h80);
      rd(8'h01);
      check("lock_read_only", rd_val, 8'h00);
      check("boost_off", boost_enable_o, 0);
   endtask : t_regs

   task automatic t_ratio();
      int base[5] = '{128, 256, 384, 512, 768};
      for (int s = 0; s < 3; s++)
         for (int c = 0; c < 5; c++)
         begin
            wr(8'h01, {1'b0, s[1:0], 2'b00, c[2:0]});
            settle();
            check("multiplier", pll_multiplier_o, base[c] >> s);
         end
   endtask : t_ratio

   task automatic t_lock();
      mclk_run <= 1'b1;
      wr(8'h01, 8'h01);
      wr(8'h01, 8'h09);
      wait_lock();
      rd(8'h01);
      check("lock_bit", rd_val, 8'h89);
      check("ref_master", pll_ref_frame_o, 0);
      wr(8'h01, 8'h09);
      settle();
      check("lock_same", pll_locked_o, 1);
      wr(8'h01, 8'h01);
      settle();
      check("lock_off", pll_locked_o, 0);
      mclk_run <= 1'b0;
      frame_run <= 1'b1;
      wr(8'h01, 8'h10);
      wr(8'h01, 8'h18);
      settle();
      check("lock_acquire", pll_locked_o, 0);
      wait_lock();
      check("ref_frame", pll_ref_frame_o, 1);
      check("mult_frame", pll_multiplier_o, 0);
   endtask : t_lock

   task automatic t_boost();
      int d[6] = '{22, 12, 30, 16, 32, 16};
      int r, n, t;
      logic p;
      wr(8'h03, 8'h04);
      for (int i = 0; i < 6; i++)
      begin
         wr(8'h02, {1'b0, i[2:1], i[0], 4'h0});
         r = 0;
         n = 0;
         t = 0;
         while (r < 3 && t < 1000)
         begin
            @(posedge mclk_i);
            p = boost_clk_o;
            if (r == 2 && pll_tick_i === 1'b1)
               n++;
            t++;
            #1;
            if (boost_clk_o === 1'b1 && p === 1'b0)
               r++;
         end
         check("boost_timeout", t < 1000, 1);
         if (t >= 1000)
            results();
         check("boost_divisor", n, d[i]);
      end
      check("boost_on", boost_enable_o, 1);
      wr(8'h03, 8'h00);
      settle();
      check("boost_stop", boost_clk_o, 0);
   endtask : t_boost

   task automatic t_bias();
      for (int i = 0; i < 16; i++)
      begin
         wr(8'h03, {i[3:0], 4'h8});
         settle();
         check("bias_level", bias_level_select_o, i);
         check("bias_mv", bias_mv_o, 5000 + 500 * (i > 8 ? 8 : i));
         check("bias_on", bias_output_en_o, 1);
      end
      wr(8'h03, 8'h00);
      settle();
      check("bias_off", bias_output_en_o, 0);
   endtask : t_bias

   task automatic t_hpf();
      send(24'sd1000, 1000);
      wr(8'h02, 8'hc0);
      send(24'sd1048576, 1048576);
      send(24'sd1048576, 1048320);
      // full-scale negative step minus the dc estimate must clip, not wrap
      send(-24'sd8388608, 32'hff800000);
      wr(8'h02, 8'h40);
      send(24'sd1048576, 1048576);
   endtask : t_hpf

   initial
   begin
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_ratio();
      t_lock();
      t_boost();
      t_bias();
      t_hpf();
      results();
   end
endmodule : testbench
